/* File: cfg_scan_pkg.sv */
/*
 * Shared constants and types for the scan-port configuration loader:
 * instruction codes, capture pattern, status word layout, TAP states,
 * host register map and link timing.
 * Assumes both ends and the bench are compiled after this package.
 */
package cfg_scan_pkg;
   // scan instruction codes
   localparam logic [3:0] INS_LOAD = 4'h5;
   localparam logic [3:0] INS_READOUT = 4'h4;
   localparam logic [3:0] INS_STARTUP_BEGIN = 4'hC;
   localparam logic [3:0] INS_INIT_TOGGLE = 4'h8;
   localparam logic [3:0] INS_BYPASS = 4'hF;
   // low capture bits of the instruction register, shifted out one then zero
   localparam logic [1:0] IR_CAPT_FIXED = 2'h1;
   // mode strap values selecting scan-port configuration
   localparam logic [2:0] MODE_SCAN_NOPULL = 3'h5;
   localparam logic [2:0] MODE_SCAN_PULL = 3'h1;
   // read-request pattern, upper word shifted first
   localparam logic [63:0] READ_REQ = 64'h2800_E001_0000_0000;
   // configuration image: data words, then one checksum word
   localparam int CFG_WORDS = 8;
   localparam logic [3:0] STARTUP_CYCLES = 4'hA;
   localparam logic [3:0] HOST_START_CLKS = 4'hA;
   // status word bit positions
   localparam int ST_DONE = 0;
   localparam int ST_INIT = 1;
   localparam int ST_LOADED = 2;
   localparam int ST_RUN = 3;
   localparam int ST_CRC = 31;
   // link timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TCK_PERIOD_NS = 160;
   localparam int TCK_HALF = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   // tms walks, first bit in bit 0
   localparam logic [4:0] PRE_TLR = 5'h1F;
   localparam logic [4:0] PRE_IR = 5'h06;
   localparam logic [4:0] PRE_DR = 5'h04;
   localparam int PRE_LEN = 5;
   localparam int TAIL_LEN = 2;
   // host register map
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_DATA = 3'h1;
   localparam logic [2:0] REG_LEN = 3'h2;
   localparam logic [2:0] REG_STAT = 3'h3;
   localparam logic [2:0] REG_RESULT = 3'h4;
   localparam logic [2:0] REG_INT_STAT = 3'h5;
   localparam logic [2:0] REG_INT_CLR = 3'h6;
   localparam logic [2:0] REG_INT_EN = 3'h7;
   localparam int CTRL_PROG_BIT = 8;
   localparam int INT_DONE = 0;
   localparam int INT_WORD = 1;

   typedef enum logic [3:0] {
      TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
      TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
      TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
   } tap_t;
   typedef enum logic [1:0] {SCLK_USER, SCLK_CFGPIN, SCLK_TCK} startclk_t;
   typedef enum logic [2:0] {CMD_NONE, CMD_RESET, CMD_CONFIG, CMD_START, CMD_STATUS} cmd_t;
   typedef enum logic [2:0] {K_END, K_TLR, K_IR, K_CFG, K_REQ, K_READ, K_CLKS} kind_t;
   typedef struct packed {
      kind_t kind;
      logic [3:0] instr;
   } step_t;
   typedef enum logic [1:0] {H_IDLE, H_PREP, H_RUN} hstate_t;
endpackage

/* File: cfg_scan_if.sv */
/*
 * Scan link between host and device: tck, tms, tdi, tdo, reconfiguration
 * pin and done pin. Assumes the bench resolves tdo from tdoEn and chains
 * tdo to the next device's tdi where several devices are used.
 */
`timescale 1ns/1ns
interface cfg_scan_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdoEn;
   logic progN;
   logic donePin;
   modport host (output tck, output tms, output tdi, output progN, input tdo);
   modport dev (input tck, input tms, input tdi, input progN, output tdo, output tdoEn,
      output donePin);
endinterface

/* File: cfg_scan_dev.sv */
/*
 * Device end of the scan configuration port: TAP, instruction and data
 * registers, configuration image with checksum, status readout, startup
 * sequencer and user pin gating.
 * Assumes pins arrive asynchronously to mclk; tck is sampled, not a clock.
 */
// Operation
// - strap 101 or 001 selects scan configuration
// - host walks five tms ones into reset
// - load instruction then bitstream becomes configuration
// - host returns to reset after bitstream
// - startup instruction plus ten shift clocks
// - startup same everywhere, clock selectable three ways
// - missing startup clock: done yet not running
// - only user outputs float during configuration
// - done means full image arrived uncorrupted
// - init pin silent, internal init holds error
// - host reads status via 64-bit request
// - readout instruction shifts 32-bit status out
// - last status bit is checksum failure
// - instruction capture gives one, zero, done, init
// - tap always active, pins dedicated
// - reconfiguration pin also resets the tap
// - scan may toggle init, never reconfiguration
// - chained devices configure through shared port
`timescale 1ns/1ns
module cfg_scan_dev
   import cfg_scan_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   cfg_scan_if.dev scan,
   input wire logic [2:0] modePins,
   input wire logic [1:0] startClkSel,
   input wire logic userClk,
   input wire logic configClockPin,
   input wire logic [7:0] userIn,
   output logic [7:0] userInSeen,
   output logic [7:0] userOut,
   output logic userOutEn,
   output logic initPin,
   output logic initInt,
   output logic operational
);
   logic [16:0] sy1_q;
   logic [16:0] sy2_q;
   logic [2:0] prev_q;
   logic [7:0] userInS;
   logic [2:0] modeS;
   logic tckS, tmsS, tdiS, progS, uclkS, cclkS;
   logic tckRise, tckFall, uclkRise, cclkRise, cfgRst;
   tap_t tap_q;
   logic [3:0] ir_q;
   logic [3:0] irSh_q;
   logic [31:0] drSh_q;
   logic [4:0] bitCnt_q;
   logic [31:0] word;
   logic [31:0] sum_q;
   logic [31:0] statusWord;
   logic [31:0] cfgMem [CFG_WORDS];
   logic [3:0] wordCnt_q;
   logic loaded_q, crcErr_q, reqSeen_q, readArm_q, initInt_q;
   logic startArm_q, run_q, scanMode_q, caught_q;
   logic [1:0] catchCnt_q;
   logic [3:0] suCnt_q;
   logic wordDone, reqStart, dataWord, chkWord, restart, suEdge, done;
   logic tdo_q, tdoEn_q;
   logic [7:0] userInSeen_q;
   logic [7:0] userOut_q;

   function automatic tap_t tapNext(input tap_t s, input logic m);
      case (s)
         TAP_TLR: return m ? TAP_TLR : TAP_RTI;
         TAP_RTI: return m ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_DR: return m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: return m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: return m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: return m ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: return m ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: return m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: return m ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_IR: return m ? TAP_TLR : TAP_CAP_IR;
         TAP_CAP_IR: return m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: return m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: return m ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: return m ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: return m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: return m ? TAP_SEL_DR : TAP_RTI;
         default: return TAP_TLR;
      endcase
   endfunction

   // two-stage synchronisers for every pin, then edge history
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sy1_q <= '0;
         sy2_q <= '0;
         prev_q <= '0;
      end else if (clkEn) begin
         sy1_q <= {userIn, configClockPin, userClk, scan.progN, scan.tdi, scan.tms,
            scan.tck, modePins};
         sy2_q <= sy1_q;
         prev_q <= {cclkS, uclkS, tckS};
      end
   end
   assign {userInS, cclkS, uclkS, progS, tdiS, tmsS, tckS, modeS} = sy2_q;

   // edges of sampled clocks, frozen while the enable is low
   assign tckRise = clkEn && tckS && !prev_q[0];
   assign tckFall = clkEn && !tckS && prev_q[0];
   assign uclkRise = clkEn && uclkS && !prev_q[1];
   assign cclkRise = clkEn && cclkS && !prev_q[2];
   assign cfgRst = !rst_n || !progS;

   // catch the mode strap once after reset release
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         caught_q <= 1'b0;
         catchCnt_q <= 2'h0;
         scanMode_q <= 1'b0;
      end else if (clkEn && !caught_q) begin
         catchCnt_q <= catchCnt_q + 2'h1;
         if (catchCnt_q == 2'h2) begin
            caught_q <= 1'b1;
            scanMode_q <= (modeS == MODE_SCAN_NOPULL) || (modeS == MODE_SCAN_PULL);
         end
      end
   end

   // tap controller runs in every mode
   always_ff @(posedge mclk) begin
      if (cfgRst) begin
         tap_q <= TAP_TLR;
      end else if (tckRise) begin
         tap_q <= tapNext(tap_q, tmsS);
      end
   end

   // instruction register with done/init capture
   always_ff @(posedge mclk) begin
      if (cfgRst) begin
         ir_q <= INS_BYPASS;
         irSh_q <= '0;
      end else if (tckRise) begin
         case (tap_q)
            TAP_CAP_IR: irSh_q <= {initInt_q, done, IR_CAPT_FIXED};
            TAP_SH_IR: irSh_q <= {tdiS, irSh_q[3:1]};
            TAP_UPD_IR: ir_q <= irSh_q;
            TAP_TLR: ir_q <= INS_BYPASS;
            default: ;
         endcase
      end
   end

   // data register: bypass bit or 32-bit word shifter
   always_ff @(posedge mclk) begin
      if (cfgRst) begin
         drSh_q <= '0;
         bitCnt_q <= '0;
      end else if (tckRise) begin
         case (tap_q)
            TAP_CAP_DR: begin
               bitCnt_q <= '0;
               drSh_q <= (ir_q == INS_READOUT && readArm_q) ? statusWord : '0;
            end
            TAP_SH_DR: begin
               bitCnt_q <= bitCnt_q + 5'h01;
               if (ir_q == INS_BYPASS) begin
                  drSh_q <= {31'h0, tdiS};
               end else begin
                  drSh_q <= {tdiS, drSh_q[31:1]};
               end
            end
            default: ;
         endcase
      end
   end

   // word classification for load traffic
   assign word = {tdiS, drSh_q[31:1]};
   assign wordDone = tckRise && tap_q == TAP_SH_DR && ir_q == INS_LOAD && bitCnt_q == 5'h1F
      && scanMode_q;
   assign reqStart = (wordCnt_q == 4'h0 || loaded_q) && word == READ_REQ[63:32];
   assign dataWord = wordDone && !reqStart && !reqSeen_q
      && (loaded_q || wordCnt_q < 4'(CFG_WORDS));
   assign chkWord = wordDone && !reqStart && !reqSeen_q && !loaded_q
      && wordCnt_q == 4'(CFG_WORDS);
   assign restart = dataWord && loaded_q;
   assign done = loaded_q && !crcErr_q;

   // image loading, checksum and read request tracking
   always_ff @(posedge mclk) begin
      if (cfgRst) begin
         wordCnt_q <= '0;
         sum_q <= '0;
         loaded_q <= 1'b0;
         crcErr_q <= 1'b0;
         reqSeen_q <= 1'b0;
         readArm_q <= 1'b0;
      end else if (wordDone) begin
         if (reqStart) begin
            reqSeen_q <= 1'b1;
         end else if (reqSeen_q) begin
            reqSeen_q <= 1'b0;
            readArm_q <= word == READ_REQ[31:0];
         end else if (dataWord) begin
            // a data word after a finished image starts a new one
            wordCnt_q <= restart ? 4'h1 : wordCnt_q + 4'h1;
            sum_q <= restart ? word : sum_q ^ word;
            loaded_q <= 1'b0;
            crcErr_q <= 1'b0;
            readArm_q <= 1'b0;
         end else if (chkWord) begin
            loaded_q <= 1'b1;
            crcErr_q <= word != sum_q;
         end
      end
   end

   // configuration memory
   always_ff @(posedge mclk) begin
      if (dataWord) begin
         cfgMem[restart ? 3'h0 : wordCnt_q[2:0]] <= word;
      end
   end

   // internal init: low on checksum error, scan may toggle it
   always_ff @(posedge mclk) begin
      if (cfgRst) begin
         initInt_q <= 1'b1;
      end else if (chkWord && word != sum_q) begin
         initInt_q <= 1'b0;
      end else if (restart) begin
         initInt_q <= 1'b1;
      end else if (tckRise && tap_q == TAP_UPD_IR && irSh_q == INS_INIT_TOGGLE) begin
         initInt_q <= !initInt_q;
      end
   end

   // startup clock selection
   always_comb begin
      case (startClkSel)
         SCLK_TCK: suEdge = tckRise && tap_q == TAP_SH_DR && ir_q == INS_STARTUP_BEGIN;
         SCLK_USER: suEdge = uclkRise;
         SCLK_CFGPIN: suEdge = cclkRise;
         default: suEdge = 1'b0;
      endcase
   end

   // startup sequencer, same count whatever the clock
   always_ff @(posedge mclk) begin
      if (cfgRst || restart) begin
         startArm_q <= 1'b0;
         suCnt_q <= '0;
         run_q <= 1'b0;
      end else if (clkEn) begin
         if (tckRise && tap_q == TAP_UPD_IR && irSh_q == INS_STARTUP_BEGIN && done) begin
            startArm_q <= 1'b1;
         end
         if (suEdge && startArm_q && !run_q) begin
            suCnt_q <= suCnt_q + 4'h1;
            if (suCnt_q == STARTUP_CYCLES - 4'h1) begin
               run_q <= 1'b1;
            end
         end
      end
   end

   // tdo changes on the falling tck edge
   always_ff @(posedge mclk) begin
      if (cfgRst) begin
         tdo_q <= 1'b0;
         tdoEn_q <= 1'b0;
      end else if (tckFall) begin
         tdo_q <= (tap_q == TAP_SH_IR) ? irSh_q[0] : drSh_q[0];
         tdoEn_q <= tap_q == TAP_SH_IR || tap_q == TAP_SH_DR;
      end
   end

   // user pins: inputs always pass, outputs only once running
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         userInSeen_q <= '0;
         userOut_q <= '0;
      end else if (clkEn) begin
         userInSeen_q <= userInS;
         userOut_q <= run_q ? cfgMem[0][7:0] : 8'h00;
      end
   end

   // status word layout
   always_comb begin
      statusWord = '0;
      statusWord[ST_DONE] = done;
      statusWord[ST_INIT] = initInt_q;
      statusWord[ST_LOADED] = loaded_q;
      statusWord[ST_RUN] = run_q;
      statusWord[ST_CRC] = crcErr_q;
   end

   // outputs
   assign scan.tdo = tdo_q;
   assign scan.tdoEn = tdoEn_q;
   assign scan.donePin = done;
   assign userInSeen = userInSeen_q;
   assign userOut = userOut_q;
   assign userOutEn = run_q;
   assign initPin = scanMode_q ? 1'b1 : initInt_q;
   assign initInt = initInt_q;
   assign operational = run_q;
endmodule

/* File: cfg_scan_host.sv */
/*
 * Host end of the scan link: register port, tck divider and a step
 * sequencer that walks the TAP for reset, configure, startup and status.
 * Assumes the device samples tms/tdi on rising tck and moves tdo on falling.
 */
`timescale 1ns/1ns
module cfg_scan_host
   import cfg_scan_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   cfg_scan_if.host scan,
   input wire logic [2:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic irq,
   output logic capDone,
   output logic capInit,
   output logic crcFail
);
   hstate_t hs_q;
   cmd_t cmd_q;
   logic [2:0] step_q;
   logic [15:0] pos_q;
   logic [3:0] cnt_q;
   logic tck_q, tms_q, tdi_q, progN_q, tdoS1_q, tdoS2_q;
   logic [63:0] shOut_q;
   logic [31:0] shIn_q;
   logic [31:0] data_q;
   logic [31:0] result_q;
   logic [31:0] rdata_q;
   logic dataV_q, crcFail_q;
   logic [7:0] len_q;
   logic [3:0] capt_q;
   logic [1:0] intStat_q;
   logic [1:0] intEn_q;
   step_t cur;
   logic [15:0] sLen, sEnd, shIdx;
   logic [4:0] pre;
   logic inShift, stepFin, needWord, take, present, cmdDone, start;

   // step table of each command
   function automatic step_t stepOf(input cmd_t c, input logic [2:0] i);
      step_t s;
      s.kind = K_END;
      s.instr = INS_BYPASS;
      case (c)
         CMD_RESET: if (i == 3'h0) s.kind = K_TLR;
         CMD_CONFIG: case (i)
            3'h0, 3'h3: s.kind = K_TLR;
            3'h1: s = '{K_IR, INS_LOAD};
            3'h2: s.kind = K_CFG;
            default: ;
         endcase
         CMD_START: case (i)
            3'h0, 3'h3: s.kind = K_TLR;
            3'h1: s = '{K_IR, INS_STARTUP_BEGIN};
            3'h2: s.kind = K_CLKS;
            default: ;
         endcase
         CMD_STATUS: case (i)
            3'h0, 3'h3, 3'h6: s.kind = K_TLR;
            3'h1: s = '{K_IR, INS_LOAD};
            3'h2: s.kind = K_REQ;
            3'h4: s = '{K_IR, INS_READOUT};
            3'h5: s.kind = K_READ;
            default: ;
         endcase
         default: ;
      endcase
      return s;
   endfunction

   // length of the shifted part of a step
   function automatic logic [15:0] shLen(input kind_t k, input logic [7:0] n);
      case (k)
         K_IR: return 16'h0004;
         K_CFG: return {3'h0, n, 5'h00};
         K_REQ: return 16'h0040;
         K_READ: return 16'h0020;
         K_CLKS: return {12'h000, HOST_START_CLKS};
         default: return 16'h0000;
      endcase
   endfunction

   // position decode within the current step
   assign cur = stepOf(cmd_q, step_q);
   assign sLen = shLen(cur.kind, len_q);
   assign sEnd = 16'(PRE_LEN) + sLen + ((sLen != 16'h0000) ? 16'(TAIL_LEN) : 16'h0000);
   assign shIdx = pos_q - 16'(PRE_LEN);
   assign inShift = pos_q >= 16'(PRE_LEN) && shIdx < sLen;
   assign pre = (cur.kind == K_TLR) ? PRE_TLR : (cur.kind == K_IR) ? PRE_IR : PRE_DR;
   assign stepFin = clkEn && hs_q == H_PREP && cur.kind != K_END && pos_q == sEnd;
   assign needWord = inShift && cur.kind == K_CFG && shIdx[4:0] == 5'h00;
   assign present = clkEn && hs_q == H_PREP && cur.kind != K_END && pos_q != sEnd
      && (!needWord || dataV_q);
   assign take = present && needWord;
   assign cmdDone = clkEn && hs_q == H_PREP && cur.kind == K_END;
   assign start = clkEn && wr && addr == REG_CTRL && hs_q == H_IDLE
      && cmd_t'(wdata[2:0]) != CMD_NONE;

   // tdo synchroniser
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tdoS1_q <= 1'b0;
         tdoS2_q <= 1'b0;
      end else if (clkEn) begin
         tdoS1_q <= scan.tdo;
         tdoS2_q <= tdoS1_q;
      end
   end

   // sequencer and tck divider; stalls tck while a word is missing
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hs_q <= H_IDLE;
         cmd_q <= CMD_NONE;
         step_q <= '0;
         pos_q <= '0;
         cnt_q <= '0;
         tck_q <= 1'b0;
         tms_q <= 1'b1;
         tdi_q <= 1'b0;
         shOut_q <= '0;
         shIn_q <= '0;
      end else if (start) begin
         cmd_q <= cmd_t'(wdata[2:0]);
         step_q <= '0;
         pos_q <= '0;
         hs_q <= H_PREP;
      end else if (cmdDone) begin
         hs_q <= H_IDLE;
      end else if (stepFin) begin
         step_q <= step_q + 3'h1;
         pos_q <= '0;
      end else if (present) begin
         if (pos_q == 16'h0000) begin
            shOut_q <= (cur.kind == K_REQ) ? {READ_REQ[31:0], READ_REQ[63:32]}
               : {60'h0, cur.instr};
         end
         if (take) begin
            shOut_q <= {32'h0, data_q};
         end
         tms_q <= (pos_q < 16'(PRE_LEN)) ? pre[pos_q[2:0]]
            : inShift ? (shIdx == sLen - 16'h0001) : (pos_q == 16'(PRE_LEN) + sLen);
         tdi_q <= take ? data_q[0] : (inShift && shOut_q[0]);
         cnt_q <= '0;
         hs_q <= H_RUN;
      end else if (clkEn && hs_q == H_RUN) begin
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == 4'(TCK_HALF - 1)) begin
            cnt_q <= '0;
            tck_q <= !tck_q;
            if (!tck_q) begin
               if (inShift) begin
                  shIn_q <= {tdoS2_q, shIn_q[31:1]};
                  shOut_q <= {1'b0, shOut_q[63:1]};
               end
               pos_q <= pos_q + 16'h0001;
            end else begin
               hs_q <= H_PREP;
            end
         end
      end
   end

   // captured results of finished steps
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         capt_q <= '0;
         result_q <= '0;
         crcFail_q <= 1'b0;
      end else if (stepFin && cur.kind == K_IR) begin
         capt_q <= shIn_q[31:28];
      end else if (stepFin && cur.kind == K_READ) begin
         result_q <= shIn_q;
         crcFail_q <= shIn_q[ST_CRC];
      end
   end

   // software registers; event set wins over clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         data_q <= '0;
         dataV_q <= 1'b0;
         len_q <= 8'h00;
         progN_q <= 1'b1;
         intStat_q <= '0;
         intEn_q <= '0;
      end else if (clkEn) begin
         if (wr && addr == REG_DATA) begin
            data_q <= wdata;
         end
         dataV_q <= (wr && addr == REG_DATA) || (dataV_q && !take);
         if (wr && addr == REG_LEN) begin
            len_q <= wdata[7:0];
         end
         if (wr && addr == REG_CTRL) begin
            progN_q <= !wdata[CTRL_PROG_BIT];
         end
         if (wr && addr == REG_INT_EN) begin
            intEn_q <= wdata[1:0];
         end
         intStat_q[INT_DONE] <= cmdDone
            || (intStat_q[INT_DONE] && !(wr && addr == REG_INT_CLR && wdata[INT_DONE]));
         intStat_q[INT_WORD] <= take
            || (intStat_q[INT_WORD] && !(wr && addr == REG_INT_CLR && wdata[INT_WORD]));
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (clkEn) begin
         rdata_q <= '0;
         if (rd) begin
            case (addr)
               REG_CTRL: rdata_q <= {23'h0, !progN_q, 7'h00, hs_q != H_IDLE};
               REG_LEN: rdata_q <= {24'h0, len_q};
               REG_STAT: rdata_q <= {26'h0, dataV_q, crcFail_q, capt_q};
               REG_RESULT: rdata_q <= result_q;
               REG_INT_STAT: rdata_q <= {30'h0, intStat_q};
               REG_INT_EN: rdata_q <= {30'h0, intEn_q};
               default: rdata_q <= '0;
            endcase
         end
      end
   end

   // outputs
   assign scan.tck = tck_q;
   assign scan.tms = tms_q;
   assign scan.tdi = tdi_q;
   assign scan.progN = progN_q;
   assign rdata = rdata_q;
   assign irq = |(intStat_q & intEn_q);
   assign capDone = capt_q[2];
   assign capInit = capt_q[3];
   assign crcFail = crcFail_q;
endmodule

/* File: cfg_scan_sva.sv */
/* link checker: watches the scan wires between host and device
   assumes every wire is sampled on mclk, rst_n synchronous active low */
`timescale 1ns/1ns
module cfg_scan_sva (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdoEn,
   input wire logic progN,
   input wire logic donePin
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // tck high phase
   sequence hiPh;
      tck[*8] ##1 !tck;
   endsequence
   // length of the current tck low phase, saturating at 15
   logic [3:0] lowCnt_q;
   always_ff @(posedge mclk) begin
      if (!rst_n || tck) begin
         lowCnt_q <= 4'h0;
      end else if (lowCnt_q != 4'hF) begin
         lowCnt_q <= lowCnt_q + 4'h1;
      end
   end
   // link wire assertions
   AST_IDLE: assert property ($rose(rst_n) |-> !tck && tms && progN)
      else $error("link not idle");
   AST_HIGH: assert property ($rose(tck) |-> hiPh)
      else $error("tck high phase");
   AST_LOW: assert property ($rose(tck) |-> lowCnt_q >= 4'h9)
      else $error("tck low phase");
   AST_EDGE: assert property (($changed(tms) || $changed(tdi)) |-> !tck)
      else $error("tms or tdi moved while tck high");
   AST_PROG: assert property ((!progN)[*6] |-> !donePin && !tdoEn)
      else $error("reconfiguration did not reset");
   AST_DONE: assert property ($rose(donePin) |-> progN)
      else $error("done rose under reconfiguration");
   AST_SHIN: assert property ($rose(tdoEn) |-> !tms)
      else $error("shift entered with tms high");
   AST_SHTCK: assert property ($rose(tdoEn) |-> !tck)
      else $error("shift entered off a tck fall");
   AST_SHOUT: assert property ($fell(tdoEn) && progN |-> tms)
      else $error("shift left with tms low");
endmodule

/* File: jtag_scan_config_port_bench.sv */
/* bench: host and device joined by the scan link, host register port driven
   assumes 100 MHz mclk and synchronous active-low reset */
`timescale 1ns/1ns
module jtag_scan_config_port_bench;
   import cfg_scan_pkg::*;
   logic mclk, rst_n, wr, rd, irq, capDone, capInit, crcFail, userOutEn, initPin, initInt;
   logic operational;
   logic [2:0] addr, modePins;
   logic [31:0] wdata, rdata, seed, st, img[9];
   logic [7:0] userIn, userInSeen, userOut;
   startclk_t sclk = SCLK_USER;
   int n_mismatch = 0;
   int checks_done = 0;
   cfg_scan_if scan ();
   cfg_scan_host cfg_scan_host_i (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1), .scan(scan.host),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .capDone(capDone), .capInit(capInit), .crcFail(crcFail));
   cfg_scan_dev cfg_scan_dev_i (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1), .scan(scan.dev),
      .modePins(modePins), .startClkSel(sclk), .userClk(1'b0), .configClockPin(1'b0),
      .userIn(userIn), .userInSeen(userInSeen), .userOut(userOut), .userOutEn(userOutEn),
      .initPin(initPin), .initInt(initInt), .operational(operational));
   cfg_scan_sva cfg_scan_sva_i (.mclk(mclk), .rst_n(rst_n), .tck(scan.tck), .tms(scan.tms),
      .tdi(scan.tdi), .tdoEn(scan.tdoEn), .progN(scan.progN), .donePin(scan.donePin));
   // xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // register port cycles
   task automatic wrReg(logic [2:0] a, logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdReg(logic [2:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 st = rdata;
      @(posedge mclk);
   endtask
   // wait for one interrupt bit, then clear it
   task automatic wt(int b);
      wrReg(REG_INT_EN, 32'h1 << b);
      for (int n = 0; n < 9000 && irq !== 1'b1; n++) @(posedge mclk);
      chk("irq", 32'h1, irq);
      wrReg(REG_INT_CLR, 32'h1 << b);
      chk("irqClr", 32'h0, irq);
   endtask
   task automatic cmd(logic [31:0] c);
      wrReg(REG_CTRL, c);
      wt(INT_DONE);
   endtask
   // image of random words plus checksum, optionally corrupted
   task automatic loadImg(logic bad);
      img[8] = 32'h0;
      for (int i = 0; i < 8; i++) begin
         img[i] = rnd();
         img[8] ^= img[i];
      end
      img[8] ^= {31'h0, bad};
      wrReg(REG_LEN, 32'h9);
      wrReg(REG_DATA, img[0]);
      wrReg(REG_INT_CLR, 32'h3);
      wrReg(REG_CTRL, 32'h2);
      for (int i = 1; i < 9; i++) begin
         wt(INT_WORD);
         wrReg(REG_DATA, img[i]);
      end
      wt(INT_DONE);
   endtask
   task automatic results();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #400000; // run needs about 17k cycles
      n_mismatch++;
      results();
   end
   // main sequence
   initial begin
      seed = 32'h4682A81F;
      {rst_n, wr, rd, addr, wdata} = '0;
      modePins = rnd() & 32'h1 ? MODE_SCAN_NOPULL : MODE_SCAN_PULL;
      userIn = 8'(rnd());
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("seen", userIn, userInSeen);
      cmd(32'h1);
      loadImg(1'b0);
      chk("done", 32'h1, scan.donePin);
      chk("idleRun", 32'h0, operational);
      // startup on a user clock that never ticks
      cmd(32'h3);
      chk("noClk", 32'h0, operational);
      chk("noClkDone", 32'h1, scan.donePin);
      sclk <= SCLK_TCK;
      cmd(32'h3);
      chk("run", 32'h1, operational);
      chk("uout", img[0][7:0], userOut);
      chk("uoutEn", 32'h1, userOutEn);
      cmd(32'h4);
      rdReg(REG_RESULT);
      chk("status", 32'h1, st & 32'h80000001);
      chk("crc", 32'h0, crcFail);
      chk("capDone", 32'h1, capDone);
      chk("capInit", 32'h1, capInit);
      wrReg(REG_CTRL, 32'h100);
      repeat (8) @(posedge mclk);
      chk("progRun", 32'h0, operational);
      wrReg(REG_CTRL, 32'h0);
      loadImg(1'b1);
      chk("badDone", 32'h0, scan.donePin);
      cmd(32'h4);
      rdReg(REG_RESULT);
      chk("badCrc", 32'h1, crcFail);
      chk("initPin", 32'h1, initPin);
      chk("initInt", 32'h0, initInt);
      chk("badInit", 32'h0, capInit);
      results();
   end
endmodule
